// ### hw/bmm_map.svh
// Purpose: register selects, field positions, reset values and burst limits
// Assumes: registers are picked by the select pointer value (pointer bits 2:0)
// Notes:   definitions only
`ifndef BMM_MAP_SVH
`define BMM_MAP_SVH
// ==========================================================
// register selects
`define BMM_SEL_BMIC       3'h4
`define BMM_SEL_MPC        3'h5
// ==========================================================
// bus master interface config fields
`define BMM_BMIC_RELOPT    6
`define BMM_BMIC_CSWAP     5
`define BMM_BMIC_BURST_HI  4
`define BMM_BMIC_BURST_LO  3
`define BMM_BMIC_DSWAP     2
`define BMM_BMIC_SPOL      1
`define BMM_BMIC_PINSEL    0
`define BMM_BMIC_RESET     7'h00
// ==========================================================
// modem pin control fields
`define BMM_MPC_TXRISE     5
`define BMM_MPC_FCEN       4
`define BMM_MPC_TRDIR      3
`define BMM_MPC_SRDIR      2
`define BMM_MPC_DTR        1
`define BMM_MPC_DSR        0
`define BMM_MPC_RESET      6'h00
// ==========================================================
// burst limits in transfers, and the frame gap that still holds rts
`define BMM_LIM_8B_SHORT   5'h02
`define BMM_LIM_8B_LONG    5'h10
`define BMM_LIM_16B_SHORT  5'h01
`define BMM_LIM_16B_LONG   5'h08
`define BMM_GAP_KEEP_MAX   5'h02
`endif

// ### hw/bmm_pkg.sv
// Purpose: shared types of the bus master and modem control block
// Assumes: nothing
// Notes:   numbers live in bmm_map.svh
package bmm_pkg;
   // ==========================================================
   // burst field encodings
   typedef enum logic [1:0] {
      BMM_BURST_SHORT = 2'b00,  // 2 bytes or 1 word
      BMM_BURST_UNL   = 2'b01,  // unlimited
      BMM_BURST_LONG  = 2'b10,  // 16 bytes or 8 words
      BMM_BURST_RSV   = 2'b11   // undefined code
   } bmm_burst_t;
endpackage : bmm_pkg

// ### hw/bmm_sync2.sv
// Purpose: two flip-flop level synchroniser
// Assumes: input is a slow level from a pin or another clock
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module bmm_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         reset,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;   // metastable stage
   // ==========================================================
   // checks
   if (W < 1) begin : g_chk
      $error("bmm_sync2: width must be at least one");
   end
   // ==========================================================
   // two stages
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : bmm_sync2

// ### hw/bmm_byte_lane.sv
// Purpose: maps a 16-bit word onto even/odd byte addresses
// Assumes: swap high puts bits 7:0 at the even address
// Notes:   the mapping is its own inverse, so one module serves both directions
`timescale 1ns/1ps
module bmm_byte_lane (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        swap,      // byte order select
   input  wire logic        valid,     // word present
   input  wire logic [15:0] word,      // word in
   output logic      [15:0] lanes_r    // {odd byte, even byte}
);
   // ==========================================================
   // registered lane mapping
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         lanes_r <= 16'h0000;
      end else if (valid) begin
         // swap set: low bits even; clear: high bits even
         lanes_r <= swap ? word : {word[7:0], word[15:8]};
      end
   end
endmodule : bmm_byte_lane

// ### hw/bmm_ctrl.sv
// Purpose: bus master interface config and modem pin control registers
// Assumes: register port on clk; transmit engine shares the link clock
// Notes:   serial data edge choice is a mux of a rising and a falling flop
//
// Contract
// - control byte-swap affects only non-data DMA
// - swap set puts bits 7:0 at even
// - control byte-swap read/write, cleared on reset
// - burst field caps transfers per ownership
// - data byte-swap affects data buffers only
// - strobe polarity selects high or low strobe
// - byte-control bit remaps three bus pins
// - edge bit moves data to rising edge
// - flow enable turns pins into RTS/CTS
// - rts low while data or transmitting
// - rts high after flag if idle/gap
// - cts high blocks start, data stays high
// - flow disabled gives general DTR/DSR pins
// - DTR direction bit sets pin direction
// - DSR direction bit sets pin direction
// - DTR bit mirrors pin or drives it
// - DSR bit mirrors pin or drives it
// - min frame gap governs own spacing
// - release option makes pin15 an input
`timescale 1ns/1ps
`include "bmm_map.svh"
module bmm_ctrl #(
   parameter int DW = 16
) (
   input  wire logic                clk,
   input  wire logic                reset,
   // register port
   input  wire logic [2:0]          reg_select_pointer,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   input  wire logic [DW-1:0]       reg_wdata,
   output logic      [DW-1:0]       reg_rdata_r,
   // dma byte ordering
   input  wire logic                dma_valid,
   input  wire logic                dma_is_data,
   input  wire logic [15:0]         dma_wr_word,
   input  wire logic [15:0]         dma_rd_lanes,
   output logic      [15:0]         dma_wr_lanes_r,
   output logic      [15:0]         dma_rd_word_r,
   // burst control
   input  wire logic                bus_8bit,
   input  wire logic                bus_owned,
   input  wire logic                dma_xfer,
   output bmm_pkg::bmm_burst_t      dma_burst_code_r,
   output logic                     burst_done_r,
   // bus pins
   input  wire logic                strobe_req,
   input  wire logic                mask_high_req,
   input  wire logic                mask_low_req,
   input  wire logic                hold_req,
   input  wire logic                grant_req,
   input  wire logic                byte_sel_req,
   input  wire logic                bus_request_out_req,
   input  wire logic                pin15_in,
   output logic                     addr_strobe_low_r,
   output logic                     pin16_out_r,
   output logic                     pin15_out_r,
   output logic                     pin15_oe_r,
   output logic                     pin17_out_r,
   output logic                     bus_release_in_r,
   // modem pins
   input  wire logic                pin26_in,
   input  wire logic                pin30_in,
   output logic                     pin26_out_r,
   output logic                     pin26_oe_r,
   output logic                     pin30_out_r,
   output logic                     pin30_oe_r,
   // transmit status, system side
   input  wire logic                tx_pending,
   input  wire logic                tx_active,
   input  wire logic                tx_flag_done,
   input  wire logic                tx_more_frames,
   input  wire logic [4:0]          min_frame_gap,
   // link side
   input  wire logic                serial_tx_clock,
   input  wire logic                tx_link_bit,
   input  wire logic                tx_link_active,
   output logic                     tx_link_may_start_r,
   output logic                     serial_tx_data
);
   import bmm_pkg::*;

   // ==========================================================
   // elaboration checks
   if (DW != 16) begin : g_chk
      $error("bmm_ctrl: register width must be 16");
   end

   // ==========================================================
   // register state
   logic [6:0]  bmic_r;       // bus master interface config bits 6:0
   logic [5:0]  mpc_r;        // modem pin control stored bits
   logic        fc_en;        // flow control enabled
   logic        rts_low_r;    // rts asserted
   logic [4:0]  burst_cnt_r;  // transfers this ownership
   logic [4:0]  burst_lim;    // cap, zero means unlimited
   logic        p15_s;        // synced pin 15
   logic        p26_s;        // synced pin 26
   logic        p30_s;        // synced pin 30
   logic        dtr_bit;      // visible dtr bit
   logic        dsr_bit;      // visible dsr bit
   logic        wr_bmic;      // write to interface config
   logic        wr_mpc;       // write to modem control

   assign wr_bmic = reg_wr && (reg_select_pointer == `BMM_SEL_BMIC);
   assign wr_mpc  = reg_wr && (reg_select_pointer == `BMM_SEL_MPC);
   assign fc_en   = mpc_r[`BMM_MPC_FCEN];

   // ==========================================================
   // pin synchronisers
   bmm_sync2 #(.W(3)) u_pin_sync (
      .clk   (clk),
      .reset (reset),
      .d     ({pin15_in, pin26_in, pin30_in}),
      .q     ({p15_s, p26_s, p30_s})
   );

   // ==========================================================
   // bus master interface config register
   // control swap cleared on reset
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bmic_r <= `BMM_BMIC_RESET;
      end else if (wr_bmic) begin
         bmic_r <= reg_wdata[6:0];
      end
   end

   // ==========================================================
   // modem pin control register
   // upper bits are not stored and read zero
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mpc_r <= `BMM_MPC_RESET;
      end else if (wr_mpc) begin
         mpc_r[5:2] <= reg_wdata[5:2];
         // dtr bit writable only as output
         if (reg_wdata[`BMM_MPC_TRDIR]) begin
            mpc_r[`BMM_MPC_DTR] <= reg_wdata[`BMM_MPC_DTR];
         end
         // dsr bit writable only as output
         if (reg_wdata[`BMM_MPC_SRDIR]) begin
            mpc_r[`BMM_MPC_DSR] <= reg_wdata[`BMM_MPC_DSR];
         end
      end
   end

   // input direction reads the live pin
   assign dtr_bit = mpc_r[`BMM_MPC_TRDIR] ? mpc_r[`BMM_MPC_DTR] : p26_s;
   assign dsr_bit = mpc_r[`BMM_MPC_SRDIR] ? mpc_r[`BMM_MPC_DSR] : p30_s;

   // ==========================================================
   // read data, registered; unselected reads return zero
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         reg_rdata_r <= 16'h0000;
      end else if (reg_rd) begin
         unique case (reg_select_pointer)
            `BMM_SEL_BMIC: reg_rdata_r <= {9'h000, bmic_r};
            `BMM_SEL_MPC:  reg_rdata_r <= {10'h000, mpc_r[5:2], dtr_bit, dsr_bit};
            default:       reg_rdata_r <= 16'h0000;
         endcase
      end
   end

   // ==========================================================
   // byte ordering; one swap bit per transfer class
   logic swap_sel;   // active swap bit
   // data swap only for data buffers
   assign swap_sel = dma_is_data ? bmic_r[`BMM_BMIC_DSWAP] : bmic_r[`BMM_BMIC_CSWAP];

   bmm_byte_lane u_wr_lane (
      .clk     (clk),
      .reset   (reset),
      .swap    (swap_sel),
      .valid   (dma_valid),
      .word    (dma_wr_word),
      .lanes_r (dma_wr_lanes_r)
   );
   // read path uses the same self-inverse mapping
   bmm_byte_lane u_rd_lane (
      .clk     (clk),
      .reset   (reset),
      .swap    (swap_sel),
      .valid   (dma_valid),
      .word    (dma_rd_lanes),
      .lanes_r (dma_rd_word_r)
   );

   // ==========================================================
   // burst limit per bus ownership
   // code to cap; code 11 treated as unlimited
   always_comb begin
      unique case (bmm_burst_t'(bmic_r[4:3]))
         BMM_BURST_SHORT: burst_lim = bus_8bit ? `BMM_LIM_8B_SHORT : `BMM_LIM_16B_SHORT;
         BMM_BURST_LONG:  burst_lim = bus_8bit ? `BMM_LIM_8B_LONG : `BMM_LIM_16B_LONG;
         BMM_BURST_UNL:   burst_lim = 5'h00;
         BMM_BURST_RSV:   burst_lim = 5'h00;
      endcase
   end

   // counter restarts each time the bus is released
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         burst_cnt_r      <= 5'h00;
         burst_done_r     <= 1'b0;
         dma_burst_code_r <= BMM_BURST_SHORT;
      end else begin
         dma_burst_code_r <= bmm_burst_t'(bmic_r[4:3]);
         if (!bus_owned) begin
            burst_cnt_r  <= 5'h00;
            burst_done_r <= 1'b0;
         end else if (dma_xfer && burst_lim != 5'h00 && !burst_done_r) begin
            // count stops at the cap so a long ownership cannot wrap it
            // done once the cap is reached
            burst_cnt_r  <= burst_cnt_r + 5'h01;
            burst_done_r <= (burst_cnt_r + 5'h01) >= burst_lim;
         end
      end
   end

   // ==========================================================
   // bus pins
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         addr_strobe_low_r <= 1'b0;
         pin16_out_r       <= 1'b0;
         pin15_out_r       <= 1'b0;
         pin15_oe_r        <= 1'b0;
         pin17_out_r       <= 1'b0;
         bus_release_in_r  <= 1'b0;
      end else begin
         // polarity 0 high latch enable, 1 low strobe
         addr_strobe_low_r <= bmic_r[`BMM_BMIC_SPOL] ? !strobe_req : strobe_req;
         // masks and hold, or grant, select and request
         pin16_out_r <= bmic_r[`BMM_BMIC_PINSEL] ? grant_req : mask_high_req;
         pin15_out_r <= bmic_r[`BMM_BMIC_PINSEL] ? byte_sel_req : mask_low_req;
         pin17_out_r <= bmic_r[`BMM_BMIC_PINSEL] ? bus_request_out_req : hold_req;
         // release option wins over byte control
         pin15_oe_r       <= !bmic_r[`BMM_BMIC_RELOPT];
         bus_release_in_r <= bmic_r[`BMM_BMIC_RELOPT] && p15_s;
      end
   end

   // ==========================================================
   // rts handling; a flag end drop wins for that one cycle so the
   // line really returns high before the next frame asks again
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rts_low_r <= 1'b0;
      end else if (!fc_en) begin
         rts_low_r <= 1'b0;
      end else if (tx_flag_done) begin
         // drop unless next frame and small gap
         rts_low_r <= tx_more_frames && (min_frame_gap <= `BMM_GAP_KEEP_MAX);
      end else if (tx_pending || tx_active) begin
         // low while data waits or is sent
         rts_low_r <= 1'b1;
      end
   end

   // ==========================================================
   // modem pins
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pin26_out_r <= 1'b0;
         pin26_oe_r  <= 1'b0;
         pin30_out_r <= 1'b0;
         pin30_oe_r  <= 1'b0;
      end else if (fc_en) begin
         // pin 26 is rts out, pin 30 cts in
         pin26_out_r <= !rts_low_r;
         pin26_oe_r  <= 1'b1;
         pin30_out_r <= 1'b0;
         pin30_oe_r  <= 1'b0;
      end else begin
         pin26_out_r <= mpc_r[`BMM_MPC_DTR];
         pin26_oe_r  <= mpc_r[`BMM_MPC_TRDIR];
         pin30_out_r <= mpc_r[`BMM_MPC_DSR];
         pin30_oe_r  <= mpc_r[`BMM_MPC_SRDIR];
      end
   end

   // ==========================================================
   // link domain: config levels and cts cross by two flops
   logic rise_sel_l; // rising edge select, link side
   logic fc_l;       // flow control, link side
   logic cts_l;      // cts pin level, link side
   logic sd_val;     // next serial data level
   logic sd_rise_r;  // data launched on rising edge
   logic sd_fall_r;  // data launched on falling edge
   bmm_sync2 #(.W(3)) u_link_sync (
      .clk   (serial_tx_clock),
      .reset (reset),
      .d     ({mpc_r[`BMM_MPC_TXRISE], fc_en, pin30_in}),
      .q     ({rise_sel_l, fc_l, cts_l})
   );
   // cts high before start keeps data high
   assign sd_val = (fc_l && cts_l && !tx_link_active) ? 1'b1 : tx_link_bit;
   // start permission and rising edge launch
   always_ff @(posedge serial_tx_clock or posedge reset) begin
      if (reset) begin
         tx_link_may_start_r <= 1'b0;
         sd_rise_r           <= 1'b1;
      end else begin
         tx_link_may_start_r <= !fc_l || !cts_l;
         sd_rise_r           <= sd_val;
      end
   end
   // falling edge launch, the default timing
   always_ff @(negedge serial_tx_clock or posedge reset) begin
      if (reset) begin
         sd_fall_r <= 1'b1;
      end else begin
         sd_fall_r <= sd_val;
      end
   end
   assign serial_tx_data = rise_sel_l ? sd_rise_r : sd_fall_r;

   // ==========================================================
   // assertions, system clock
   logic live_r;   // low through the release edge so no check starts on reset values
   // checks stay off until the first edge after reset has been taken
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         live_r <= 1'b0;
      end else begin
         live_r <= 1'b1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset || !live_r);

   ctrl_swap_a : assert property (dma_valid && !dma_is_data |=>
      dma_wr_lanes_r[7:0] == ($past(bmic_r[5]) ? $past(dma_wr_word[7:0])
                                               : $past(dma_wr_word[15:8])))
      else $error("control byte order wrong");
   data_swap_a : assert property (dma_valid && dma_is_data |=>
      dma_wr_lanes_r[15:8] == ($past(bmic_r[2]) ? $past(dma_wr_word[15:8])
                                                : $past(dma_wr_word[7:0])))
      else $error("data byte order wrong");
   cfg_write_a : assert property (wr_bmic && !reg_rd ##1 reg_rd &&
      reg_select_pointer == `BMM_SEL_BMIC && !reg_wr
      |=> reg_rdata_r[5] == $past(reg_wdata[5], 2))
      else $error("control swap bit not stored");
   burst_unl_a : assert property (bmic_r[4:3] == 2'b01 && $stable(bmic_r)
      |=> !burst_done_r)
      else $error("unlimited burst ended");
   burst_word_a : assert property (bus_owned && !bus_8bit && bmic_r[4:3] == 2'b00
      && dma_xfer && $stable(bmic_r) ##1 bus_owned |-> burst_done_r)
      else $error("single word burst not capped");
   strobe_pol_a : assert property (1'b1 |=>
      addr_strobe_low_r == ($past(bmic_r[1]) ^ $past(strobe_req)))
      else $error("strobe polarity wrong");
   byte_pin_a : assert property (!bmic_r[0] |=> pin17_out_r == $past(hold_req))
      else $error("hold pin not mapped");
   release_pin_a : assert property (bmic_r[6] |=> !pin15_oe_r)
      else $error("pin 15 driven under release option");
   sequence s_fc_busy;
      fc_en && tx_active && !tx_flag_done;
   endsequence
   rts_low_a : assert property (s_fc_busy ##1 fc_en |=> !pin26_out_r && pin26_oe_r)
      else $error("rts not low while sending");
   sequence s_flag_idle;
      fc_en && tx_flag_done && (!tx_more_frames || min_frame_gap > 5'h02);
   endsequence
   rts_high_a : assert property (s_flag_idle ##1 fc_en |=> pin26_out_r)
      else $error("rts not released after flag");
   dir_dtr_a : assert property (!fc_en && mpc_r[3] |=> pin26_oe_r)
      else $error("dtr output not enabled");
   cts_input_a : assert property (fc_en |=> !pin30_oe_r)
      else $error("cts pin driven");

   // ==========================================================
   // assertion, link clock
   sd_idle_a : assert property (@(posedge serial_tx_clock) disable iff (reset)
      fc_l && cts_l && !tx_link_active |=> sd_rise_r && !tx_link_may_start_r)
      else $error("serial data not held high under cts");
endmodule : bmm_ctrl

// ### tb/bmm_modem.sv
// Purpose: modem side of the dtr/rts and dsr/cts pins
// Assumes: the modem drives a pin only while the block has released it
// Notes:   modem levels are set by the bench
`timescale 1ns/1ps
module bmm_modem (
   input  wire logic pin26_out_r,  // block drive, dtr/rts
   input  wire logic pin26_oe_r,   // block enable, dtr/rts
   input  wire logic pin30_out_r,  // block drive, dsr/cts
   input  wire logic pin30_oe_r,   // block enable, dsr/cts
   input  wire logic cts_high,     // modem level on dsr/cts
   input  wire logic dtr_level,    // modem level on dtr/rts
   output logic      pin26_in,     // wire level, dtr/rts
   output logic      pin30_in      // wire level, dsr/cts
);
   // ==========================================
   // wire levels: the block wins while it drives
   assign pin26_in = pin26_oe_r ? pin26_out_r : dtr_level;
   assign pin30_in = pin30_oe_r ? pin30_out_r : cts_high;
endmodule : bmm_modem

// ### tb/bus_master_and_modem_ctrl_tb.sv
// Purpose: self-checking bench of the bus master and modem control block
// Assumes: modem model on the far pins, link clock free running
// Notes:   waits are fixed counts taken from the hand-over latencies
`timescale 1ns/1ps
module bus_master_and_modem_ctrl_tb;
   import bmm_pkg::*;
   typedef struct {logic [2:0] s; logic [15:0] d; logic [15:0] q; logic [4:0] p;} bmm_row_t;
   typedef struct {logic [15:0] c; logic b; int n; logic e;} bmm_bst_t;
   logic clk = 0, reset = 1, serial_tx_clock = 0, reg_wr = 0, reg_rd = 0;
   logic [2:0]  reg_select_pointer = 3'h0;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata_r, dma_wr_lanes_r, dma_rd_word_r, v;
   logic [15:0] dma_wr_word = 16'h1234, dma_rd_lanes = 16'hABCD;
   logic dma_valid = 0, dma_is_data = 0, bus_8bit = 0, bus_owned = 0, dma_xfer = 0;
   logic strobe_req = 1, mask_high_req = 1, mask_low_req = 0, hold_req = 1, w;
   logic grant_req = 0, byte_sel_req = 1, bus_request_out_req = 0, pin15_in = 1;
   logic tx_pending = 0, tx_active = 0, tx_flag_done = 0, tx_more_frames = 0;
   logic tx_link_bit = 0, tx_link_active = 0, cts_high = 0, dtr_level = 0;
   logic [4:0]  min_frame_gap = 5'h00;
   logic burst_done_r, addr_strobe_low_r, pin16_out_r, pin15_out_r, pin15_oe_r;
   logic pin17_out_r, bus_release_in_r, pin26_in, pin30_in, pin26_out_r;
   logic pin26_oe_r, pin30_out_r, pin30_oe_r, tx_link_may_start_r, serial_tx_data;
   bmm_burst_t  dma_burst_code_r;
   int          miscompares = 0, num_checks = 0;
   // rows keep reserved modem bits zero; the second row writes burst code 11
   // register rows: select, write, read back, {strobe, pin16, pin15, pin17, pin15 oe}
   bmm_row_t rows [6] = '{'{3'h4, 16'h0003, 16'h0003, 5'h05}, '{3'h4, 16'h003C, 16'h003C, 5'h1B},
      '{3'h5, 16'h0003, 16'h0000, 5'h1B}, '{3'h2, 16'hFFFF, 16'h0000, 5'h1B},
      '{3'h4, 16'hFFAF, 16'h002F, 5'h05}, '{3'h4, 16'h0024, 16'h0024, 5'h1B}};
   // burst rows: config, 8-bit bus, transfers, cap reached
   bmm_bst_t bst [8] = '{'{16'h0000, 0, 1, 1}, '{16'h0000, 1, 1, 0}, '{16'h0000, 1, 2, 1},
      '{16'h0010, 1, 15, 0}, '{16'h0010, 1, 16, 1}, '{16'h0010, 0, 7, 0},
      '{16'h0010, 0, 8, 1}, '{16'h0008, 0, 20, 0}};
   // ==========================================
   // clocks: system 40 ns, link 64 ns
   always #20 clk = ~clk;
   always #32 serial_tx_clock = ~serial_tx_clock;
   bmm_ctrl i_bmm_ctrl (.clk, .reset, .reg_select_pointer, .reg_wr, .reg_rd, .reg_wdata,
      .reg_rdata_r, .dma_valid, .dma_is_data, .dma_wr_word, .dma_rd_lanes, .dma_wr_lanes_r,
      .dma_rd_word_r, .bus_8bit, .bus_owned, .dma_xfer, .dma_burst_code_r, .burst_done_r,
      .strobe_req, .mask_high_req, .mask_low_req, .hold_req, .grant_req, .byte_sel_req,
      .bus_request_out_req, .pin15_in, .addr_strobe_low_r, .pin16_out_r, .pin15_out_r, .pin15_oe_r,
      .pin17_out_r, .bus_release_in_r, .pin26_in, .pin30_in, .pin26_out_r, .pin26_oe_r,
      .pin30_out_r, .pin30_oe_r, .tx_pending, .tx_active, .tx_flag_done, .tx_more_frames,
      .min_frame_gap, .serial_tx_clock, .tx_link_bit, .tx_link_active,
      .tx_link_may_start_r, .serial_tx_data);
   bmm_modem i_bmm_modem (.pin26_out_r, .pin26_oe_r, .pin30_out_r, .pin30_oe_r, .cts_high,
      .dtr_level, .pin26_in, .pin30_in);
   // ==========================================
   // tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic wr(input logic [2:0] s, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1;
      reg_select_pointer <= s;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 0;
   endtask : wr
   task automatic rd(input logic [2:0] s, output logic [15:0] q);
      @(posedge clk);
      reg_rd <= 1;
      reg_select_pointer <= s;
      @(posedge clk);
      reg_rd <= 0;
      #1 q = reg_rdata_r;
   endtask : rd
   // closing flag with the next frame state, then rts two cycles on
   task automatic flag(input logic m, input logic [4:0] g, input logic p, input logic e);
      @(posedge clk);
      tx_flag_done <= 1;
      tx_more_frames <= m;
      min_frame_gap <= g;
      tx_pending <= p;
      tx_active <= p;
      @(posedge clk);
      tx_flag_done <= 0;
      cyc(1);
      chk(pin26_out_r, e);
   endtask : flag
   task automatic wrap_up;
      if (miscompares == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : wrap_up
   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      wrap_up();
   end
   // ==========================================
   // main sequence
   initial begin
      repeat (8) @(posedge clk);
      chk(serial_tx_data, 1);
      reset <= 0;
      rd(3'h4, v);
      chk(v, 16'h0000);
      foreach (rows[i]) begin
         wr(rows[i].s, rows[i].d);
         rd(rows[i].s, v);
         chk(v, rows[i].q);
         chk({addr_strobe_low_r, pin16_out_r, pin15_out_r, pin17_out_r, pin15_oe_r}, rows[i].p);
      end
      // write then read on the next edge, back to back
      @(posedge clk);
      reg_wr <= 1;
      reg_wdata <= 16'h0000;
      @(posedge clk);
      reg_wr <= 0;
      reg_rd <= 1;
      @(posedge clk);
      reg_rd <= 0;
      #1 chk(reg_rdata_r, 16'h0000);
      // software sets the control and data byte-swap bits in the swap runs
      for (int s = 0; s < 4; s++) begin
         wr(3'h4, {10'h000, s[1], 2'h0, s[0], 2'h0});
         for (int d = 0; d < 2; d++) begin
            @(posedge clk);
            dma_valid <= 1;
            dma_is_data <= d[0];
            cyc(1);
            w = d[0] ? s[0] : s[1];
            chk(dma_wr_lanes_r, w ? 16'h1234 : 16'h3412);
            chk(dma_rd_word_r, w ? 16'hABCD : 16'hCDAB);
         end
      end
      foreach (bst[i]) begin
         wr(3'h4, bst[i].c);
         @(posedge clk);
         bus_8bit <= bst[i].b;
         bus_owned <= 1;
         dma_xfer <= 1;
         repeat (bst[i].n) @(posedge clk);
         dma_xfer <= 0;
         #1 chk(burst_done_r, bst[i].e);
         chk(dma_burst_code_r, bst[i].c[4:3]);
         @(posedge clk);
         bus_owned <= 0;
         cyc(2);
         chk(burst_done_r, 0);
      end
      wr(3'h4, 16'h0041);
      cyc(5);
      chk({pin15_oe_r, bus_release_in_r}, 2'h1);
      @(posedge clk);
      pin15_in <= 0;
      cts_high <= 1;
      cyc(5);
      chk(bus_release_in_r, 0);
      wr(3'h5, 16'h0010);
      cyc(8);
      chk({pin26_oe_r, pin30_oe_r, pin26_out_r}, 3'h5);
      chk({tx_link_may_start_r, serial_tx_data}, 2'h1);
      @(posedge clk);
      tx_pending <= 1;
      cts_high <= 0;
      cyc(2);
      chk(pin26_out_r, 0);
      cyc(8);
      chk({tx_link_may_start_r, serial_tx_data, pin26_out_r}, 3'h4);
      flag(1, 5'h02, 1, 0);
      flag(1, 5'h03, 1, 1);
      flag(0, 5'h00, 0, 1);
      wr(3'h5, 16'h0030);
      cyc(8);
      @(posedge serial_tx_clock);
      tx_link_bit <= 1;
      @(negedge serial_tx_clock);
      #1 chk(serial_tx_data, 0);
      @(posedge serial_tx_clock);
      #1 chk(serial_tx_data, 1);
      wr(3'h5, 16'h0010);
      cyc(8);
      @(posedge serial_tx_clock);
      tx_link_bit <= 0;
      @(negedge serial_tx_clock);
      #1 chk(serial_tx_data, 0);
      wr(3'h5, 16'h000E);
      cyc(1);
      chk({pin26_oe_r, pin26_out_r, pin30_oe_r, pin30_out_r}, 4'hE);
      wr(3'h5, 16'h000D);
      rd(3'h5, v);
      chk(v, 16'h000D);
      chk({pin26_oe_r, pin26_out_r, pin30_oe_r, pin30_out_r}, 4'hB);
      @(posedge clk);
      dtr_level <= 1;
      wr(3'h5, 16'h0003);
      cyc(3);
      rd(3'h5, v);
      chk(v, 16'h0002);
      chk({pin26_oe_r, pin30_oe_r}, 2'h0);
      @(posedge clk);
      reset <= 1;
      cyc(4);
      @(posedge clk);
      reset <= 0;
      rd(3'h4, v);
      chk(v, 16'h0000);
      wrap_up();
   end
endmodule : bus_master_and_modem_ctrl_tb
